// ===== rtl/phy_evt_pkg.sv
package phy_evt_pkg;

    // management register addresses
    localparam logic [4:0] ADDR_IRQ_CTRL = 5'h11;
    localparam logic [4:0] ADDR_EVT = 5'h12;
    localparam logic [4:0] ADDR_PAGE = 5'h13;
    localparam logic [4:0] ADDR_FC = 5'h14;
    localparam logic [4:0] ADDR_RXERR = 5'h15;

    // page pointer values
    localparam logic [1:0] PAGE_EXT0 = 2'h0;
    localparam logic [1:0] PAGE_DIAG = 2'h2;

    // interrupt control field positions
    localparam int CTRL_PIN_BIT = 0;
    localparam int CTRL_MASTER_BIT = 1;
    localparam int CTRL_TEST_BIT = 2;

    // event register layout: pending high byte, allow low byte
    localparam int PEND_LSB = 8;
    localparam int ALLOW_LSB = 0;

    // reset values
    localparam logic [2:0] IRQ_CTRL_RST = 3'h0;
    localparam logic [7:0] PEND_RST = 8'h00;
    localparam logic [7:0] ALLOW_RST = 8'h00;
    localparam logic [1:0] PAGE_RST = 2'h0;
    localparam logic [7:0] TALLY_RST = 8'h00;
    localparam logic [7:0] TALLY_MAX = 8'hff;

    // management frame
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [5:0] HDR_LAST = 6'h0b;
    localparam logic [5:0] DATA_LAST = 6'h0f;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    // value arbitrary
    localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h01;

    typedef struct packed {
        logic linkQuality;
        logic energyDetect;
        logic linkChange;
        logic speedChange;
        logic duplexChange;
        logic autonegDone;
    } phy_events_t;

    typedef enum logic [2:0] {
        MS_PRE = 3'b000,
        MS_START = 3'b001,
        MS_HDR = 3'b010,
        MS_TA = 3'b011,
        MS_DATA = 3'b100
    } mgmt_state_t;

endpackage

// ===== rtl/sat_tally.sv
`timescale 1ns/1ps
module sat_tally
    import phy_evt_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // control
    input wire logic incr,
    input wire logic clear,
    // state
    output logic [7:0] count,
    output logic halfPulse
);

    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic half_reg;
    wire atMax = (count_reg == TALLY_MAX);

    // an event in the clearing cycle is kept as the first count
    assign count_next = clear ? {7'h00, incr} :
        (incr && !atMax) ? count_reg + 8'h01 : count_reg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= TALLY_RST;
            half_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            half_reg <= count_next[7] & ~count_reg[7];
        end
    end

    assign count = count_reg;
    assign halfPulse = half_reg;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_tally_sticks: assert property (
        atMax && !clear |=> count_reg == TALLY_MAX)
        else $error("tally left its maximum");

    a_tally_clears: assert property (
        clear && !incr |=> count_reg == 8'h00)
        else $error("tally not cleared by read");

    a_tally_steps: assert property (
        incr && !clear && !atMax |=> count_reg == $past(count_reg) + 8'h01)
        else $error("tally did not step by one");

    a_half_flag: assert property (
        half_reg |-> count_reg[7] && !$past(count_reg[7]))
        else $error("half flag without crossing 128");

endmodule // sat_tally

// ===== rtl/phy_event_irq.sv
// Behaviour
// - status bit holds until event register read
// - event irq needs event allow plus master controls
// - status recorded regardless of any allow
// - pending bits 15..8, reset 0, clear on read
// - allow bits 7..0 gate events, reset 0
// - page field picks set at 14h..1Fh
// - reserved upper bits ignore writes, read 0
// - false carrier tally 8 bits, clear on read
// - false carrier tally sticks at FFh
// - rx error tally counts errored valid carriers
// - rx error tally once per carrier
// - no rx error count with collision
// - rx error tally sticks at maximum
// - tallies at 14h/15h on page 0
// - test bit forces irq while set
// - master bit gates all event irqs
// - pin bit: irq output or powerdown input
`timescale 1ns/1ps
module phy_event_irq
    import phy_evt_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEFAULT
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // management pins
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    // events from other units
    input wire phy_events_t events,
    input wire logic falseCarrier,
    // receive carrier status
    input wire logic carrierValid,
    input wire logic invalidSymbol,
    input wire logic collision,
    // shared powerdown or irq pin, irq active low
    input wire logic powerdownOrIrqPinIn,
    output logic powerdownOrIrqPinOut,
    output logic powerdownOrIrqPinOe,
    output logic powerDownReq
);

    // pin sampling: three stages, level taken once 2 and 3 agree
    logic [2:0] mdcSync_reg;
    logic [2:0] mdioSync_reg;
    logic [2:0] pinSync_reg;
    logic mdcLvl_reg;
    logic mdioLvl_reg;
    logic pinLvl_reg;

    wire mdcAgree = mdcSync_reg[1] == mdcSync_reg[2];
    wire mdioAgree = mdioSync_reg[1] == mdioSync_reg[2];
    wire pinAgree = pinSync_reg[1] == pinSync_reg[2];
    wire mdcRise = mdcAgree & mdcSync_reg[2] & ~mdcLvl_reg;
    wire mdioBit = mdioAgree ? mdioSync_reg[2] : mdioLvl_reg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mdcSync_reg <= 3'h0;
            mdioSync_reg <= 3'h7;
            pinSync_reg <= 3'h7;
            mdcLvl_reg <= 1'b0;
            mdioLvl_reg <= 1'b1;
            pinLvl_reg <= 1'b1;
        end else begin
            mdcSync_reg <= {mdcSync_reg[1:0], mdc};
            mdioSync_reg <= {mdioSync_reg[1:0], mdioIn};
            pinSync_reg <= {pinSync_reg[1:0], powerdownOrIrqPinIn};
            mdcLvl_reg <= mdcAgree ? mdcSync_reg[2] : mdcLvl_reg;
            mdioLvl_reg <= mdioAgree ? mdioSync_reg[2] : mdioLvl_reg;
            pinLvl_reg <= pinAgree ? pinSync_reg[2] : pinLvl_reg;
        end
    end

    // register state
    logic [2:0] intCtrl_reg;
    logic [2:0] intCtrl_next;
    logic [7:0] pending_reg;
    logic [7:0] pending_next;
    logic [7:0] allow_reg;
    logic [7:0] allow_next;
    logic [1:0] page_reg;
    logic [1:0] page_next;
    logic [7:0] fcCount;
    logic [7:0] rxCount;
    logic fcHalf;
    logic rxHalf;

    // management frame state
    mgmt_state_t state_reg;
    mgmt_state_t state_next;
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic [11:0] hdr_reg;
    logic [11:0] hdr_next;
    logic [15:0] wr_reg;
    logic [15:0] wr_next;
    logic [15:0] rd_reg;
    logic [15:0] rd_next;
    logic reading_reg;
    logic reading_next;
    logic mdioOut_reg;
    logic mdioOut_next;
    logic mdioOe_reg;
    logic mdioOe_next;

    // frame decode
    wire [11:0] hdrFull = {hdr_reg[10:0], mdioBit};
    wire hdrDone = mdcRise && state_reg == MS_HDR && cnt_reg == HDR_LAST;
    wire dataDone = mdcRise && state_reg == MS_DATA && cnt_reg == DATA_LAST;
    wire [11:0] decHdr = hdrDone ? hdrFull : hdr_reg;
    wire [1:0] decOp = decHdr[11:10];
    wire [4:0] decAddr = decHdr[4:0];
    wire phyMatch = decHdr[9:5] == PHY_ADDR;
    wire page0 = page_reg == PAGE_EXT0;
    wire selCtrl = decAddr == ADDR_IRQ_CTRL;
    wire selEvt = decAddr == ADDR_EVT;
    wire selPage = decAddr == ADDR_PAGE;
    // other pages belong to units outside this block
    wire selFc = page0 && decAddr == ADDR_FC;
    wire selRx = page0 && decAddr == ADDR_RXERR;
    wire ownHit = phyMatch && (selCtrl || selEvt || selPage || selFc || selRx);
    wire readHit = hdrDone && decOp == OP_READ && ownHit;
    wire writeHit = dataDone && decOp == OP_WRITE && ownHit;
    wire [15:0] wrWord = {wr_reg[14:0], mdioBit};

    wire [15:0] rdWord =
        selCtrl ? {13'h0000, intCtrl_reg} :
        selEvt ? {pending_reg, allow_reg} :
        selPage ? {14'h0000, page_reg} :
        selFc ? {8'h00, fcCount} :
        selRx ? {8'h00, rxCount} : 16'h0000;

    // management frame sequencer, advanced on each mdc rise
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        hdr_next = hdr_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        reading_next = reading_reg;
        mdioOut_next = mdioOut_reg;
        mdioOe_next = mdioOe_reg;
        if (mdcRise) begin
            case (state_reg)
                MS_PRE: begin
                    if (mdioBit) begin
                        if (cnt_reg != PREAMBLE_ONES) begin
                            cnt_next = cnt_reg + 6'h01;
                        end
                    end else begin
                        cnt_next = 6'h00;
                        if (cnt_reg == PREAMBLE_ONES) begin
                            state_next = MS_START;
                        end
                    end
                end
                MS_START: begin
                    cnt_next = 6'h00;
                    state_next = mdioBit ? MS_HDR : MS_PRE;
                end
                MS_HDR: begin
                    hdr_next = hdrFull;
                    cnt_next = cnt_reg + 6'h01;
                    if (cnt_reg == HDR_LAST) begin
                        state_next = MS_TA;
                        cnt_next = 6'h00;
                        reading_next = readHit;
                        rd_next = rdWord;
                    end
                end
                MS_TA: begin
                    if (cnt_reg == 6'h00) begin
                        mdioOe_next = reading_reg;
                        mdioOut_next = 1'b0;
                        cnt_next = 6'h01;
                    end else begin
                        mdioOut_next = rd_reg[15];
                        rd_next = {rd_reg[14:0], 1'b0};
                        state_next = MS_DATA;
                        cnt_next = 6'h00;
                    end
                end
                MS_DATA: begin
                    wr_next = wrWord;
                    mdioOut_next = rd_reg[15];
                    rd_next = {rd_reg[14:0], 1'b0};
                    cnt_next = cnt_reg + 6'h01;
                    if (cnt_reg == DATA_LAST) begin
                        mdioOe_next = 1'b0;
                        reading_next = 1'b0;
                        state_next = MS_PRE;
                        cnt_next = 6'h00;
                    end
                end
                default: begin
                    state_next = MS_PRE;
                    cnt_next = 6'h00;
                    mdioOe_next = 1'b0;
                    reading_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= MS_PRE;
            cnt_reg <= 6'h00;
            hdr_reg <= 12'h000;
            wr_reg <= 16'h0000;
            rd_reg <= 16'h0000;
            reading_reg <= 1'b0;
            mdioOut_reg <= 1'b1;
            mdioOe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            hdr_reg <= hdr_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            reading_reg <= reading_next;
            mdioOut_reg <= mdioOut_next;
            mdioOe_reg <= mdioOe_next;
        end
    end

    // receive error carrier tracking; counted when carrier ends
    logic carrierPrev_reg;
    logic symSeen_reg;
    logic collSeen_reg;
    wire carrierEnd = carrierPrev_reg & ~carrierValid;
    // one count per carrier, none with collision
    wire rxErrInc = carrierEnd & symSeen_reg & ~collSeen_reg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            carrierPrev_reg <= 1'b0;
            symSeen_reg <= 1'b0;
            collSeen_reg <= 1'b0;
        end else begin
            carrierPrev_reg <= carrierValid;
            symSeen_reg <= carrierValid & (symSeen_reg | invalidSymbol);
            collSeen_reg <= carrierValid & (collSeen_reg | collision);
        end
    end

    wire fcRead = readHit & selFc;
    wire rxRead = readHit & selRx;

    sat_tally fcTally (
        .core_clk(core_clk),
        .rstn(rstn),
        .incr(falseCarrier),
        .clear(fcRead),
        .count(fcCount),
        .halfPulse(fcHalf)
    );
    sat_tally rxTally (
        .core_clk(core_clk),
        .rstn(rstn),
        .incr(rxErrInc),
        .clear(rxRead),
        .count(rxCount),
        .halfPulse(rxHalf)
    );

    // event status: set wins over the read clear so nothing is lost
    wire [7:0] evtVec = {events, fcHalf, rxHalf};
    wire statusRead = readHit & selEvt;
    assign pending_next = (statusRead ? PEND_RST : pending_reg)
        | evtVec;

    // only documented bits are stored; the rest never exist
    assign intCtrl_next = (writeHit && selCtrl) ? wrWord[2:0]
        : intCtrl_reg;
    assign allow_next = (writeHit && selEvt) ? wrWord[ALLOW_LSB +: 8]
        : allow_reg;
    assign page_next = (writeHit && selPage) ? wrWord[1:0]
        : page_reg;

    wire eventIrq = intCtrl_reg[CTRL_MASTER_BIT]
        & |(pending_reg & allow_reg);
    wire irqActive = intCtrl_reg[CTRL_TEST_BIT] | eventIrq;
    wire pinIsIrq = intCtrl_reg[CTRL_PIN_BIT];

    logic irqPinOut_reg;
    logic irqPinOe_reg;
    logic powerDown_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            intCtrl_reg <= IRQ_CTRL_RST;
            pending_reg <= PEND_RST;
            allow_reg <= ALLOW_RST;
            page_reg <= PAGE_RST;
            irqPinOut_reg <= 1'b1;
            irqPinOe_reg <= 1'b0;
            powerDown_reg <= 1'b0;
        end else begin
            intCtrl_reg <= intCtrl_next;
            pending_reg <= pending_next;
            allow_reg <= allow_next;
            page_reg <= page_next;
            irqPinOut_reg <= ~irqActive;
            irqPinOe_reg <= pinIsIrq;
            powerDown_reg <= ~pinIsIrq & ~pinLvl_reg;
        end
    end

    assign mdioOut = mdioOut_reg;
    assign mdioOe = mdioOe_reg;
    assign powerdownOrIrqPinOut = irqPinOut_reg;
    assign powerdownOrIrqPinOe = irqPinOe_reg;
    assign powerDownReq = powerDown_reg;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence sStatusRead;
        statusRead && evtVec == 8'h00;
    endsequence
    sequence sQuietAfter;
        evtVec == 8'h00 [*2];
    endsequence

    a_pending_sticky: assert property (
        !statusRead |=> (pending_reg & $past(pending_reg))
            == $past(pending_reg))
        else $error("pending bit lost without a read");
    a_event_recorded: assert property (
        evtVec != 8'h00 |=> (pending_reg & $past(evtVec))
            == $past(evtVec))
        else $error("event not recorded as pending");
    a_read_clears: assert property (
        sStatusRead |=> pending_reg == 8'h00)
        else $error("status read left pending bits");
    a_irq_released: assert property (
        sStatusRead ##0 !intCtrl_reg[CTRL_TEST_BIT] ##1 sQuietAfter
            |-> powerdownOrIrqPinOut)
        else $error("irq held after status read");
    a_irq_gated: assert property (
        !intCtrl_reg[CTRL_TEST_BIT] && !(intCtrl_reg[CTRL_MASTER_BIT]
            && (pending_reg & allow_reg) != 8'h00)
            |=> powerdownOrIrqPinOut)
        else $error("irq without allow and master");
    a_test_irq: assert property (
        intCtrl_reg[CTRL_TEST_BIT] [*2] |-> !powerdownOrIrqPinOut)
        else $error("test bit did not force irq");
    a_pin_dir: assert property (
        ##1 powerdownOrIrqPinOe == $past(intCtrl_reg[CTRL_PIN_BIT]))
        else $error("pin direction not following control");
    a_rx_no_coll: assert property (
        carrierValid && collision |=> !rxErrInc)
        else $error("rx error counted with collision");
    a_rx_once: assert property (
        rxErrInc |=> !rxErrInc)
        else $error("rx error counted twice per carrier");
    a_page_tally: assert property (
        readHit && selFc |=> rd_reg == {8'h00, $past(fcCount)})
        else $error("false carrier tally not at its address");
endmodule // phy_event_irq

// ===== sim/mgmt_station.sv
`timescale 1ns/1ps
module mgmt_station
    import phy_evt_pkg::*;
(
    // clock
    input wire logic core_clk,
    // management pins
    output logic mdc,
    output logic mdioDrive,
    output logic mdioDriveOe,
    input wire logic mdioLine
);
    logic sampled;

    initial begin
        mdc = 1'b0;
        mdioDrive = 1'b1;
        mdioDriveOe = 1'b0;
        sampled = 1'b1;
    end

    // 6 core_clk per half period; sample just before the rise,
    // which leaves the device's synchroniser delay well inside the bit
    task automatic mdc_bit(input logic b, input logic drv);
        mdioDrive = b;
        mdioDriveOe = drv;
        repeat (6) @(posedge core_clk);
        #1;
        sampled = mdioLine;
        mdc = 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        mdc = 1'b0;
    endtask

    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
            input logic [4:0] regAddr, input logic [15:0] wdata,
            output logic [15:0] rdata);
        logic [13:0] hdr;
        logic isRead;
        hdr = {2'b01, op, phy, regAddr};
        isRead = (op == OP_READ);
        for (int i = 0; i < 32; i++) begin
            mdc_bit(1'b1, 1'b1);
        end
        for (int i = 13; i >= 0; i--) begin
            mdc_bit(hdr[i], 1'b1);
        end
        // turnaround released on reads
        mdc_bit(1'b1, !isRead);
        mdc_bit(1'b0, !isRead);
        for (int i = 15; i >= 0; i--) begin
            mdc_bit(wdata[i], !isRead);
            rdata[i] = sampled;
        end
        mdioDriveOe = 1'b0;
        repeat (8) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] unused;
        frame(OP_WRITE, PHY_ADDR_DEFAULT, a, d, unused);
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        frame(OP_READ, PHY_ADDR_DEFAULT, a, 16'h0000, d);
    endtask
endmodule // mgmt_station

// ===== sim/phy_event_irq_and_error_counters_tb.sv
`timescale 1ns/1ps
module phy_event_irq_and_error_counters_tb;
    import phy_evt_pkg::*;
    logic core_clk;
    logic rstn;
    logic mdc;
    logic mdioOut;
    logic mdioOe;
    logic stDrive;
    logic stOe;
    logic mdioLine;
    phy_events_t events;
    logic falseCarrier;
    logic carrierValid;
    logic invalidSymbol;
    logic collision;
    logic pinDrv;
    logic pinLine;
    logic pinOut;
    logic pinOe;
    logic powerDownReq;
    logic [15:0] rdata;
    int n_fail;
    int n_checks;

    // released mdio floats high through its pull-up
    assign mdioLine = mdioOe ? mdioOut : (stOe ? stDrive : 1'b1);
    assign pinLine = pinOe ? pinOut : pinDrv;

    phy_event_irq phy_event_irq_inst (
        .core_clk(core_clk), .rstn(rstn), .mdc(mdc),
        .mdioIn(mdioLine), .mdioOut(mdioOut), .mdioOe(mdioOe),
        .events(events), .falseCarrier(falseCarrier),
        .carrierValid(carrierValid), .invalidSymbol(invalidSymbol),
        .collision(collision), .powerdownOrIrqPinIn(pinLine),
        .powerdownOrIrqPinOut(pinOut), .powerdownOrIrqPinOe(pinOe),
        .powerDownReq(powerDownReq)
    );

    mgmt_station mgmt_station_inst (
        .core_clk(core_clk), .mdc(mdc), .mdioDrive(stDrive),
        .mdioDriveOe(stOe), .mdioLine(mdioLine)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp,
            input string what);
        mgmt_station_inst.rd(a, rdata);
        check(what, exp, rdata);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgmt_station_inst.wr(a, d);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic ev_pulse(input phy_events_t v);
        events = v;
        wait_clk(1);
        events = '0;
        wait_clk(1);
    endtask

    task automatic fc_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            falseCarrier = 1'b1;
            wait_clk(1);
            falseCarrier = 1'b0;
            wait_clk(1);
        end
    endtask

    task automatic carrier(input int nBad, input logic coll);
        carrierValid = 1'b1;
        collision = coll;
        for (int i = 0; i < 3; i++) begin
            invalidSymbol = (i < nBad);
            wait_clk(1);
        end
        invalidSymbol = 1'b0;
        collision = 1'b0;
        carrierValid = 1'b0;
        wait_clk(2);
    endtask

    task automatic t_reset();
        for (int a = 5'h11; a <= 5'h15; a++) begin
            rd_chk(5'(a), 16'h0000, "reset value");
        end
        check("pin oe", 16'h0, 16'(pinOe));
        check("irq idle", 16'h1, 16'(pinOut));
        $display("test reset done");
    endtask

    task automatic t_events();
        for (int i = 0; i < 6; i++) begin
            ev_pulse(phy_events_t'(6'h01 << i));
            wait_clk(20);
            rd_chk(ADDR_EVT, 16'h0400 << i, "pending");
            rd_chk(ADDR_EVT, 16'h0000, "cleared");
        end
        $display("test events done");
    endtask

    task automatic t_gating();
        wr(ADDR_IRQ_CTRL, 16'h0001);
        wr(ADDR_EVT, 16'hff20);
        rd_chk(ADDR_EVT, 16'h0020, "allow");
        ev_pulse(phy_events_t'(6'h08));
        wait_clk(4);
        check("irq master off", 16'h1, 16'(pinOut));
        wr(ADDR_IRQ_CTRL, 16'h0003);
        check("irq on", 16'h0, 16'(pinOut));
        check("pin oe", 16'h1, 16'(pinOe));
        rd_chk(ADDR_EVT, 16'h2020, "pending link");
        check("irq released", 16'h1, 16'(pinOut));
        ev_pulse(phy_events_t'(6'h10));
        wait_clk(4);
        check("irq not allowed", 16'h1, 16'(pinOut));
        rd_chk(ADDR_EVT, 16'h4020, "pending energy");
        $display("test gating done");
    endtask

    task automatic t_forced();
        wr(ADDR_IRQ_CTRL, 16'h0005);
        wait_clk(50);
        check("forced irq", 16'h0, 16'(pinOut));
        wr(ADDR_IRQ_CTRL, 16'h0001);
        check("forced off", 16'h1, 16'(pinOut));
        $display("test forced done");
    endtask

    task automatic t_pin();
        wr(ADDR_IRQ_CTRL, 16'hfff8);
        rd_chk(ADDR_IRQ_CTRL, 16'h0000, "ctrl reserved");
        check("pin input", 16'h0, 16'(pinOe));
        pinDrv = 1'b0;
        wait_clk(8);
        check("powerdown", 16'h1, 16'(powerDownReq));
        pinDrv = 1'b1;
        wait_clk(8);
        check("powerdown off", 16'h0, 16'(powerDownReq));
        $display("test pin done");
    endtask

    task automatic t_mid_reset();
        wr(ADDR_PAGE, {14'h0, PAGE_DIAG});
        wr(ADDR_IRQ_CTRL, 16'h0005);
        check("irq before reset", 16'h0, 16'(pinOut));
        rstn = 1'b0;
        wait_clk(2);
        check("oe in reset", 16'h0, 16'(pinOe));
        check("irq in reset", 16'h1, 16'(pinOut));
        rstn = 1'b1;
        wait_clk(6);
        rd_chk(ADDR_IRQ_CTRL, 16'h0000, "ctrl after reset");
        rd_chk(ADDR_PAGE, 16'h0000, "page after reset");
        $display("test mid reset done");
    endtask

    task automatic t_page();
        wr(ADDR_PAGE, 16'hffff);
        rd_chk(ADDR_PAGE, 16'h0003, "page bits");
        rd_chk(ADDR_FC, 16'hffff, "page 3 fc");
        wr(ADDR_PAGE, 16'h0001);
        rd_chk(ADDR_RXERR, 16'hffff, "page 1 rxerr");
        wr(ADDR_PAGE, {14'h0, PAGE_DIAG});
        rd_chk(ADDR_FC, 16'hffff, "page 2 fc");
        wr(ADDR_PAGE, {14'h0, PAGE_EXT0});
        mgmt_station_inst.frame(2'b11, PHY_ADDR_DEFAULT, ADDR_PAGE,
            16'h0002, rdata);
        rd_chk(ADDR_PAGE, 16'h0000, "bad op refused");
        wr(ADDR_FC, 16'hffff);
        rd_chk(ADDR_FC, 16'h0000, "fc write");
        mgmt_station_inst.frame(OP_READ, 5'h02, ADDR_PAGE, 16'h0, rdata);
        check("other phy", 16'hffff, rdata);
        $display("test page done");
    endtask

    task automatic t_false_carrier();
        wr(ADDR_EVT, 16'h0002);
        wr(ADDR_IRQ_CTRL, 16'h0003);
        fc_pulses(5);
        rd_chk(ADDR_FC, 16'h0005, "fc count");
        rd_chk(ADDR_FC, 16'h0000, "fc cleared");
        fc_pulses(127);
        rd_chk(ADDR_EVT, 16'h0002, "no half at 127");
        check("irq at 127", 16'h1, 16'(pinOut));
        fc_pulses(1);
        wait_clk(4);
        check("irq at 128", 16'h0, 16'(pinOut));
        rd_chk(ADDR_EVT, 16'h0202, "half at 128");
        fc_pulses(200);
        rd_chk(ADDR_FC, 16'h00ff, "fc sticks");
        $display("test false carrier done");
    endtask

    task automatic t_rx_error();
        carrier(3, 1'b0);
        carrier(0, 1'b0);
        carrier(2, 1'b1);
        rd_chk(ADDR_RXERR, 16'h0001, "rx once");
        rd_chk(ADDR_RXERR, 16'h0000, "rx cleared");
        for (int i = 0; i < 260; i++) begin
            carrier(1, 1'b0);
        end
        wr(ADDR_RXERR, 16'hffff);
        rd_chk(ADDR_RXERR, 16'h00ff, "rx sticks");
        rd_chk(ADDR_EVT, 16'h0102, "rx half");
        $display("test rx error done");
    endtask

    // about 56 frames of ~780 cycles each, plus traffic
    initial begin
        wait_clk(80000);
        n_fail++;
        give_verdict();
    end

    initial begin
        n_fail = 0;
        n_checks = 0;
        rstn = 1'b0;
        events = '0;
        falseCarrier = 1'b0;
        carrierValid = 1'b0;
        invalidSymbol = 1'b0;
        collision = 1'b0;
        pinDrv = 1'b1;
        wait_clk(5);
        rstn = 1'b1;
        wait_clk(6);
        t_reset();
        t_events();
        t_gating();
        t_forced();
        t_pin();
        t_mid_reset();
        t_page();
        t_false_carrier();
        t_rx_error();
        give_verdict();
    end
endmodule // phy_event_irq_and_error_counters_tb
